/* include/fllcs_cfg.svh */
// How it works
// - status bit 4 shows the reference source in use: 1 internal, 0 external
// - status bits 3-2 show active mode: loop output, bypass internal, bypass external
// - reference and mode status change only after a clock-domain synchronisation delay
// - status bit 1 sets after oscillator init cycles when requested and reference used
// - oscillator-ready clears when oscillator request clears, or external enable is off while no external-reference mode is active
// - bit 0 is finest trim: set lengthens internal reference period, clear shortens
// - source select 00 with reference select 1 is default loop-engaged internal mode
// - running loop locks output to 1024 times the divided reference frequency
// - source select 00 with reference select 0 runs loop locked to external reference
// - select 01, reference 1, debug or low-power 0: internal out, loop and debug clock run
// - select 01, reference 1, no debug, low-power 1: internal out, loop and debug clock off
// - select 10, reference 0, debug or low-power 0: external out, loop and debug clock run
// - select 10, reference 0, no debug, low-power 1: external out, loop and debug clock off
// - stop holds clocks static; internal ref output runs if enable and stop-enable set
// - in stop the external ref output runs only if enable and stop-enable both set
// - after reference change loop relocks after a few new divided reference cycles
// - output moves to new clock after a few of its cycles; absent clock keeps old one
// - bus divider writes take effect immediately without synchronisation
// - internal reference enable presents internal reference as an auxiliary clock output
// - larger coarse trim lengthens internal period; affects output in internal modes
// - coarse and fine trim keep their contents through reset
// - bus divider codes 00-11 divide by 1,2,4,8; resets to 01
// - reference divider divides by powers of two, code 000 by one; resets to 000
`ifndef FLLCS_CFG_SVH
`define FLLCS_CFG_SVH

// register byte offsets
`define FLLCS_OFS_CTRL1   4'h0
`define FLLCS_OFS_CTRL2   4'h4
`define FLLCS_OFS_TRIM    4'h8
`define FLLCS_OFS_STATUS  4'hc

// control 1 fields
`define FLLCS_C1_SRC_HI   7
`define FLLCS_C1_SRC_LO   6
`define FLLCS_C1_REFERENCE_DIVIDER_HI  5
`define FLLCS_C1_REFERENCE_DIVIDER_LO  3
`define FLLCS_C1_REFSEL   2
`define FLLCS_C1_IRCEN    1
`define FLLCS_C1_IRCSTEN  0
`define FLLCS_C1_RESET    8'h04

// control 2 fields
`define FLLCS_C2_BUS_DIVIDER_HI  7
`define FLLCS_C2_BUS_DIVIDER_LO  6
`define FLLCS_C2_LP       3
`define FLLCS_C2_OSCREQ   2
`define FLLCS_C2_ERCEN    1
`define FLLCS_C2_ERCSTEN  0
`define FLLCS_C2_RESET    8'h40

// status fields
`define FLLCS_ST_REFST    4
`define FLLCS_ST_MODE_HI  3
`define FLLCS_ST_MODE_LO  2
`define FLLCS_ST_OSCRDY   1
`define FLLCS_ST_FINE_TRIM_BIT    0

// timing counts
`define FLLCS_SWITCH_CYC  3'd4
`define FLLCS_LOCK_REFS   3'd4
`define FLLCS_IRC_BASE    10'd16
`define FLLCS_FLL_LOG2    10
`define FLLCS_OSC_INIT    4096

`endif

/* include/fllcs_pkg.sv */
package fllcs_pkg;
   typedef enum logic [1:0] {
      FLLCS_MODE_LOOP,
      FLLCS_MODE_BYP_INT,
      FLLCS_MODE_BYP_EXT
   } fllcs_mode_e;
endpackage

/* hdl/fllcs_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
module fllcs_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   // data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule // fllcs_sync2
`default_nettype wire

/* hdl/fllcs_pow2_div.sv */
`timescale 1ns/1ns
`default_nettype none
module fllcs_pow2_div #(
   parameter int SW = 3
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          sys_rst,
   // ticks
   input  wire logic          tick_in,
   input  wire logic [SW-1:0] log2_sel,
   output logic               tick_out
);
   localparam int CW = (1 << SW) - 1;

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] mask;

   // mask compare, not reload, so a new ratio acts on the very next tick
   always_comb begin
      mask     = CW'(({{CW{1'b0}}, 1'b1} << log2_sel) - 1'b1);
      tick_out = tick_in && ((cnt_q & mask) == mask);
      cnt_d    = tick_in ? cnt_q + 1'b1 : cnt_q;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // fllcs_pow2_div
`default_nettype wire

/* hdl/fllcs_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fllcs_cfg.svh"
module fllcs_top
   import fllcs_pkg::*;
#(
   parameter int OSC_INIT_EDGES = `FLLCS_OSC_INIT
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // register bus
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // external reference pin
   input  wire logic        ext_ref_pin,
   // chip state
   input  wire logic        stop_mode,
   input  wire logic        debug_mode,
   // clock outputs
   output logic             main_clock_out,
   output logic             bus_clock_out,
   output logic             debug_link_clock,
   output logic             int_ref_clock_out,
   output logic             ext_ref_clock_out,
   output logic             fll_locked
);
   // registers
   logic [7:0]  ctl1_q, ctl1_d;
   logic [7:0]  ctl2_q, ctl2_d;
   logic [7:0]  trim_register_q, trim_register_d;
   logic        fine_trim_bit_q, fine_trim_bit_d;
   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic        bus_req;
   logic [2:0]  st_sync;

   // fields
   logic [1:0]  clock_source_select;
   logic [2:0]  reference_divider;
   logic        reference_select;
   logic        int_ref_out_enable;
   logic        int_ref_stop_enable;
   logic [1:0]  bus_divider;
   logic        low_power_bit;
   logic        oscillator_request;
   logic        ext_ref_out_enable;
   logic        ext_ref_stop_enable;

   always_comb begin
      clock_source_select = ctl1_q[`FLLCS_C1_SRC_HI:`FLLCS_C1_SRC_LO];
      reference_divider   = ctl1_q[`FLLCS_C1_REFERENCE_DIVIDER_HI:`FLLCS_C1_REFERENCE_DIVIDER_LO];
      reference_select    = ctl1_q[`FLLCS_C1_REFSEL];
      int_ref_out_enable  = ctl1_q[`FLLCS_C1_IRCEN];
      int_ref_stop_enable = ctl1_q[`FLLCS_C1_IRCSTEN];
      bus_divider         = ctl2_q[`FLLCS_C2_BUS_DIVIDER_HI:`FLLCS_C2_BUS_DIVIDER_LO];
      low_power_bit       = ctl2_q[`FLLCS_C2_LP];
      oscillator_request  = ctl2_q[`FLLCS_C2_OSCREQ];
      ext_ref_out_enable  = ctl2_q[`FLLCS_C2_ERCEN];
      ext_ref_stop_enable = ctl2_q[`FLLCS_C2_ERCSTEN];
   end

   // internal reference oscillator model, half period in core cycles
   logic [9:0] irc_cnt_q, irc_cnt_d;
   logic [9:0] irc_half;
   logic       irc_tick;

   always_comb begin
      irc_half  = `FLLCS_IRC_BASE + {1'b0, trim_register_q, fine_trim_bit_q};
      irc_tick  = (irc_cnt_q >= irc_half);
      irc_cnt_d = irc_tick ? 10'h000 : irc_cnt_q + 10'h001;
   end

   // external reference, synchronised pin then edge
   logic ext_s;
   logic ext_prev_q;
   logic ext_tick;

   fllcs_sync2 #(.W(1)) u_ext_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in (ext_ref_pin),
      .sync_out (ext_s)
   );

   assign ext_tick = ext_s && !ext_prev_q;

   // reference source switch
   logic       ref_source_q, ref_source_d;
   logic [2:0] rsw_cnt_q, rsw_cnt_d;
   logic       rsw_tick;

   always_comb begin
      rsw_tick     = reference_select ? irc_tick : ext_tick;
      ref_source_d = ref_source_q;
      rsw_cnt_d    = 3'h0;
      if (reference_select != ref_source_q) begin
         // switch after a few edges of the new reference
         rsw_cnt_d = rsw_tick ? rsw_cnt_q + 3'h1 : rsw_cnt_q;
         if (rsw_tick && rsw_cnt_q == `FLLCS_SWITCH_CYC - 3'h1) begin
            ref_source_d = reference_select;
            rsw_cnt_d    = 3'h0;
         end
      end
   end

   // clock mode switch
   fllcs_mode_e clk_mode_q, clk_mode_d;
   fllcs_mode_e target_mode;
   logic [2:0]  csw_cnt_q, csw_cnt_d;
   logic        fll_tick;
   logic        target_tick;
   logic        fll_en;

   always_comb begin
      unique case (clock_source_select)
         2'b01:   target_mode = FLLCS_MODE_BYP_INT;
         2'b10:   target_mode = FLLCS_MODE_BYP_EXT;
         default: target_mode = FLLCS_MODE_LOOP;
      endcase
      unique case (target_mode)
         FLLCS_MODE_BYP_INT: target_tick = irc_tick;
         FLLCS_MODE_BYP_EXT: target_tick = ext_tick;
         default:            target_tick = fll_tick;
      endcase
      clk_mode_d = clk_mode_q;
      csw_cnt_d  = 3'h0;
      // a clock that never ticks keeps the old one selected
      if (target_mode != clk_mode_q) begin
         csw_cnt_d = target_tick ? csw_cnt_q + 3'h1 : csw_cnt_q;
         if (target_tick && csw_cnt_q == `FLLCS_SWITCH_CYC - 3'h1) begin
            clk_mode_d = target_mode;
            csw_cnt_d  = 3'h0;
         end
      end
   end

   // loop stays off only if both current and wanted modes are low-power bypass
   always_comb begin
      fll_en = !(clk_mode_q != FLLCS_MODE_LOOP && target_mode != FLLCS_MODE_LOOP
                 && low_power_bit && !debug_mode);
   end

   // divided loop reference
   logic dref_tick;

   fllcs_pow2_div #(.SW(3)) u_ref_div (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .tick_in  (ref_source_q ? irc_tick : ext_tick),
      .log2_sel (reference_divider),
      .tick_out (dref_tick)
   );

   // loop model: measure divided ref period, output period is 1/1024 of it
   logic [15:0] per_cnt_q, per_cnt_d;
   logic [15:0] per_q, per_d;
   logic [2:0]  lock_cnt_q, lock_cnt_d;
   logic        lock_q, lock_d;
   logic        lock_ref_q;
   logic [5:0]  fll_step;
   logic [5:0]  fll_cnt_q, fll_cnt_d;

   always_comb begin
      per_cnt_d  = dref_tick ? 16'h0000 : per_cnt_q + 16'h0001;
      per_d      = dref_tick ? per_cnt_q : per_q;
      lock_cnt_d = lock_cnt_q;
      lock_d     = lock_q;
      if (!fll_en || ref_source_q != lock_ref_q) begin
         lock_cnt_d = 3'h0;
         lock_d     = 1'b0;
      end else if (dref_tick && !lock_q) begin
         lock_cnt_d = lock_cnt_q + 3'h1;
         lock_d     = (lock_cnt_q == `FLLCS_LOCK_REFS - 3'h1);
      end
      // fastest modelled output is one tick per core cycle
      fll_step  = per_q[`FLLCS_FLL_LOG2 +: 6];
      fll_tick  = fll_en && lock_q && (fll_step == 6'h00 || fll_cnt_q >= fll_step - 6'h01);
      fll_cnt_d = (fll_tick || !fll_en) ? 6'h00 : fll_cnt_q + 6'h01;
   end

   // oscillator start-up
   logic [12:0] osc_cnt_q, osc_cnt_d;
   logic        osc_rdy_q, osc_rdy_d;
   logic        ext_in_use;

   always_comb begin
      ext_in_use = clk_mode_q == FLLCS_MODE_BYP_EXT
                   || (clk_mode_q == FLLCS_MODE_LOOP && !ref_source_q);
      osc_cnt_d  = osc_cnt_q;
      osc_rdy_d  = osc_rdy_q;
      // an external-reference mode keeps the flag alive with the output enable off
      if (!oscillator_request || !(ext_ref_out_enable || ext_in_use)) begin
         osc_cnt_d = 13'h0000;
         osc_rdy_d = 1'b0;
      end else if (!osc_rdy_q && ext_tick) begin
         osc_cnt_d = osc_cnt_q + 13'h0001;
         if (osc_cnt_q == 13'(OSC_INIT_EDGES - 1)) begin
            osc_rdy_d = 1'b1;
         end
      end
   end

   // selected clock and bus divider
   logic sel_tick;
   logic bus_tick;

   always_comb begin
      unique case (clk_mode_q)
         FLLCS_MODE_BYP_INT: sel_tick = irc_tick;
         FLLCS_MODE_BYP_EXT: sel_tick = ext_tick;
         default:            sel_tick = fll_tick;
      endcase
   end

   fllcs_pow2_div #(.SW(2)) u_bus_div (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .tick_in  (sel_tick),
      .log2_sel (bus_divider),
      .tick_out (bus_tick)
   );

   // clock outputs
   logic main_q, main_d;
   logic bus_q, bus_d;
   logic dbg_q, dbg_d;
   logic irc_out_q, irc_out_d;
   logic erc_out_q, erc_out_d;

   always_comb begin
      main_d    = (sel_tick && !stop_mode) ? !main_q : main_q;
      bus_d     = (bus_tick && !stop_mode) ? !bus_q : bus_q;
      dbg_d     = (fll_tick && !stop_mode) ? !dbg_q : dbg_q;
      irc_out_d = irc_out_q;
      if (int_ref_out_enable && (!stop_mode || int_ref_stop_enable) && irc_tick) begin
         irc_out_d = !irc_out_q;
      end
      erc_out_d = erc_out_q;
      if (ext_ref_out_enable && (!stop_mode || ext_ref_stop_enable)) begin
         erc_out_d = ext_s;
      end
   end

   // reference and mode status cross two stages before reads
   fllcs_sync2 #(.W(3)) u_st_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in ({ref_source_q, clk_mode_q}),
      .sync_out (st_sync)
   );

   // bus slave: one wait cycle, read data ready when waitrequest drops
   logic [7:0] rsel;

   always_comb begin
      bus_req         = avs_read || avs_write;
      wait_d          = !(bus_req && wait_q);
      ctl1_d          = ctl1_q;
      ctl2_d          = ctl2_q;
      trim_register_d = trim_register_q;
      fine_trim_bit_d = fine_trim_bit_q;
      unique case (avs_address)
         `FLLCS_OFS_CTRL1:  rsel = ctl1_q;
         `FLLCS_OFS_CTRL2:  rsel = ctl2_q;
         `FLLCS_OFS_TRIM:   rsel = trim_register_q;
         `FLLCS_OFS_STATUS: rsel = {3'h0, st_sync, osc_rdy_q, fine_trim_bit_q};
         default:           rsel = 8'h00;
      endcase
      rdata_d = (avs_read && wait_q) ? {24'h000000, rsel} : rdata_q;
      if (avs_write && !wait_q) begin
         unique case (avs_address)
            `FLLCS_OFS_CTRL1:  ctl1_d = avs_writedata[7:0];
            `FLLCS_OFS_CTRL2:  ctl2_d = avs_writedata[7:0];
            `FLLCS_OFS_TRIM:   trim_register_d = avs_writedata[7:0];
            `FLLCS_OFS_STATUS: fine_trim_bit_d = avs_writedata[`FLLCS_ST_FINE_TRIM_BIT];
            default:           ;
         endcase
      end
   end

   // trim state sits outside the reset branch so it survives any reset
   always_ff @(posedge core_clk) begin
      trim_register_q <= trim_register_d;
      fine_trim_bit_q <= fine_trim_bit_d;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctl1_q       <= `FLLCS_C1_RESET;
         ctl2_q       <= `FLLCS_C2_RESET;
         wait_q       <= 1'b1;
         rdata_q      <= 32'h00000000;
         irc_cnt_q    <= 10'h000;
         ext_prev_q   <= 1'b0;
         ref_source_q <= 1'b1;
         rsw_cnt_q    <= 3'h0;
         clk_mode_q   <= FLLCS_MODE_LOOP;
         csw_cnt_q    <= 3'h0;
         per_cnt_q    <= 16'h0000;
         per_q        <= 16'h0000;
         lock_cnt_q   <= 3'h0;
         lock_q       <= 1'b0;
         lock_ref_q   <= 1'b1;
         fll_cnt_q    <= 6'h00;
         osc_cnt_q    <= 13'h0000;
         osc_rdy_q    <= 1'b0;
         main_q       <= 1'b0;
         bus_q        <= 1'b0;
         dbg_q        <= 1'b0;
         irc_out_q    <= 1'b0;
         erc_out_q    <= 1'b0;
      end else begin
         ctl1_q       <= ctl1_d;
         ctl2_q       <= ctl2_d;
         wait_q       <= wait_d;
         rdata_q      <= rdata_d;
         irc_cnt_q    <= irc_cnt_d;
         ext_prev_q   <= ext_s;
         ref_source_q <= ref_source_d;
         rsw_cnt_q    <= rsw_cnt_d;
         clk_mode_q   <= clk_mode_d;
         csw_cnt_q    <= csw_cnt_d;
         per_cnt_q    <= per_cnt_d;
         per_q        <= per_d;
         lock_cnt_q   <= lock_cnt_d;
         lock_q       <= lock_d;
         lock_ref_q   <= ref_source_q;
         fll_cnt_q    <= fll_cnt_d;
         osc_cnt_q    <= osc_cnt_d;
         osc_rdy_q    <= osc_rdy_d;
         main_q       <= main_d;
         bus_q        <= bus_d;
         dbg_q        <= dbg_d;
         irc_out_q    <= irc_out_d;
         erc_out_q    <= erc_out_d;
      end
   end

   assign avs_readdata      = rdata_q;
   assign avs_waitrequest   = wait_q;
   assign main_clock_out    = main_q;
   assign bus_clock_out     = bus_q;
   assign debug_link_clock  = dbg_q;
   assign int_ref_clock_out = irc_out_q;
   assign ext_ref_clock_out = erc_out_q;
   assign fll_locked        = lock_q;
endmodule // fllcs_top
`default_nettype wire

/* tb/fllcs_osc_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fllcs_osc_model #(
   parameter int HALF_NS = 40
) (
   // oscillator pin
   output logic ext_ref_pin
);
   // free running crystal; odd start offset keeps its edges off core_clk edges
   initial begin
      ext_ref_pin = 1'b0;
      #3;
      forever #HALF_NS ext_ref_pin = ~ext_ref_pin;
   end
endmodule // fllcs_osc_model
`default_nettype wire

/* tb/fllcs_chk_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module fllcs_chk_sva (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        sys_rst,
   // register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // chip state and clocks
   input wire logic        stop_mode,
   input wire logic        main_clock_out,
   input wire logic        bus_clock_out,
   input wire logic        debug_link_clock
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence req_waiting;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence status_answer;
      avs_read && !avs_waitrequest && avs_address == 4'hc;
   endsequence
   // registered outputs may still land one edge as stop arrives
   sequence stop_held;
      stop_mode [*3];
   endsequence
   AST_ONE_WAIT: assert property (req_waiting |=> !avs_waitrequest)
      else $error("bus answer late");
   AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   AST_NO_SPURIOUS: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
   AST_READ_HOLD: assert property (!$stable(avs_readdata) |-> !avs_waitrequest && avs_read)
      else $error("read data moved outside a read");
   AST_STATUS_RSVD: assert property (status_answer |-> avs_readdata[31:5] == 27'h0)
      else $error("status reserved bits set");
   AST_MODE_CODE: assert property (status_answer |-> avs_readdata[3:2] != 2'b11)
      else $error("status shows reserved mode");
   AST_STOP_MAIN: assert property (stop_held |-> $stable(main_clock_out))
      else $error("main clock runs in stop");
   AST_STOP_BUS: assert property (stop_held |-> $stable(bus_clock_out))
      else $error("bus clock runs in stop");
   AST_STOP_DBG: assert property (stop_held |-> $stable(debug_link_clock))
      else $error("debug clock runs in stop");
endmodule // fllcs_chk_sva
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fllcs_cfg.svh"
module tb_top;
   localparam logic [3:0] C1 = `FLLCS_OFS_CTRL1;
   localparam logic [3:0] C2 = `FLLCS_OFS_CTRL2;
   localparam logic [3:0] TR = `FLLCS_OFS_TRIM;
   localparam logic [3:0] ST = `FLLCS_OFS_STATUS;
   localparam int MAIN = 0, BUS = 1, DBG = 2, IRC = 3, ERC = 4;
   // internal ref half period in core cycles with coarse trim 0 and fine trim 1
   localparam int IRCP = `FLLCS_IRC_BASE + 2;
   logic        core_clk, sys_rst, avs_read, avs_write, stop_mode, debug_mode;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        avs_waitrequest, ext_ref_pin, fll_locked;
   logic        main_clock_out, bus_clock_out, debug_link_clock;
   logic        int_ref_clock_out, ext_ref_clock_out;
   logic [4:0]  clk_v;
   logic [7:0]  v;
   int          fails, checks, n, m;
   assign clk_v = {ext_ref_clock_out, int_ref_clock_out, debug_link_clock,
                   bus_clock_out, main_clock_out};

   fllcs_osc_model #(.HALF_NS(40)) osc (.ext_ref_pin(ext_ref_pin));
   fllcs_top #(.OSC_INIT_EDGES(8)) dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_ref_pin(ext_ref_pin), .stop_mode(stop_mode), .debug_mode(debug_mode),
      .main_clock_out(main_clock_out), .bus_clock_out(bus_clock_out),
      .debug_link_clock(debug_link_clock), .int_ref_clock_out(int_ref_clock_out),
      .ext_ref_clock_out(ext_ref_clock_out), .fll_locked(fll_locked));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // request held until waitrequest is sampled low; read data taken at that edge
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      if (k >= 20) fails++;
      v = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic poll(input logic [3:0] a, input logic [7:0] mk, input logic [7:0] e);
      int k;
      k = 0;
      do begin
         xfer(1'b0, a, 8'h0);
         k++;
      end while ((v & mk) !== e && k < 400);
   endtask

   // cycles until the chosen clock output next changes
   task automatic next_toggle(input int idx);
      logic p;
      n = 0;
      #1 p = clk_v[idx];
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (clk_v[idx] === p && n < 2000);
   endtask

   task automatic toggles(input int idx, input int cyc);
      logic p;
      m = 0;
      #1 p = clk_v[idx];
      repeat (cyc) begin
         @(posedge core_clk);
         #1;
         if (clk_v[idx] !== p) m++;
         p = clk_v[idx];
      end
   endtask

   task automatic do_reset;
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
   endtask

   initial begin
      static logic [7:0] mc1 [4] = '{8'h80, 8'h00, 8'h44, 8'h04};
      static logic [7:0] mst [4] = '{8'h08, 8'h00, 8'h14, 8'h10};
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      stop_mode = 1'b0;
      debug_mode = 1'b0;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      // trim is never reset; give it a value, then reset away the unknown ref counter
      xfer(1, TR, 8'h00);
      xfer(1, ST, 8'h00);
      do_reset;
      xfer(0, C1, 0); check("ctrl1", v, 8'h04);
      xfer(0, C2, 0); check("ctrl2", v, 8'h40);
      xfer(0, ST, 0); check("status", v & 8'h1e, 8'h10);
      xfer(0, 4'h2, 0); check("unmapped", v, 8'h00);
      xfer(1, ST, 8'hfe); xfer(0, ST, 0); check("status_wr", v & 8'he1, 8'h00);
      xfer(1, C1, 8'h06);
      for (int t = 0; t < 3; t++) begin
         xfer(1, TR, (t == 1) ? 8'h01 : 8'h00);
         xfer(1, ST, (t == 2) ? 8'h01 : 8'h00);
         next_toggle(IRC);
         next_toggle(IRC);
         check("irc_gap", n, 17 + ((t == 1) ? 2 : 0) + ((t == 2) ? 1 : 0));
      end
      xfer(1, TR, 8'h5a);
      do_reset;
      xfer(0, TR, 0); check("trim_kept", v, 8'h5a);
      xfer(0, ST, 0); check("fine_trim_bit_kept", v & 8'h01, 8'h01);
      xfer(1, TR, 8'h00);
      xfer(1, C2, 8'h46); xfer(0, ST, 0); check("osc_early", v & 8'h02, 8'h00);
      poll(ST, 8'h02, 8'h02); check("osc_ready", v & 8'h02, 8'h02);
      xfer(1, C2, 8'h4e); xfer(0, ST, 0); check("osc_kept", v & 8'h02, 8'h02);
      for (int i = 0; i < 2; i++) begin
         xfer(1, C2, 8'h4e);
         poll(ST, 8'h02, 8'h02);
         xfer(1, C2, i ? 8'h4a : 8'h4c);
         xfer(0, ST, 0); check("osc_clear", v & 8'h02, 8'h00);
      end
      xfer(1, C2, 8'h46);
      xfer(1, C1, mc1[0]); xfer(0, ST, 0); check("status_sync", v & 8'h1c, 8'h10);
      for (int i = 0; i < 4; i++) begin
         xfer(1, C1, mc1[i]);
         poll(ST, 8'h1c, mst[i]); check("mode", v & 8'h1c, mst[i]);
      end
      n = 0;
      while (fll_locked !== 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      check("locked", fll_locked, 1'b1);
      xfer(1, C1, 8'h44);
      poll(ST, 8'h0c, 8'h04);
      for (int b = 0; b < 4; b++) begin
         xfer(1, C2, {b[1:0], 6'h06});
         next_toggle(BUS); check("bus_gap", n <= (IRCP << b), 1'b1);
         next_toggle(BUS); check("bus_ratio", n, IRCP << b);
      end
      next_toggle(MAIN);
      next_toggle(MAIN); check("main_gap", n, IRCP);
      for (int i = 0; i < 2; i++) begin
         xfer(1, C2, i ? 8'h4e : 8'h48);
         xfer(1, C1, i ? 8'h80 : 8'h44);
         poll(ST, 8'h0c, i ? 8'h08 : 8'h04);
         repeat (40) @(posedge core_clk);
         toggles(DBG, 200); check("dbg_off", m, 0);
         @(posedge core_clk);
         debug_mode <= 1'b1;
         repeat (100) @(posedge core_clk);
         toggles(DBG, 200); check("dbg_on", m != 0, 1'b1);
         @(posedge core_clk);
         debug_mode <= 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
         xfer(1, C2, i ? 8'h42 : 8'h43);
         xfer(1, C1, i ? 8'h46 : 8'h47);
         poll(ST, 8'h0c, 8'h04);
         @(posedge core_clk);
         stop_mode <= 1'b1;
         repeat (4) @(posedge core_clk);
         toggles(IRC, 400); check("irc_stop", m != 0, !i);
         toggles(ERC, 400); check("erc_stop", m != 0, !i);
         toggles(MAIN, 50); check("main_stop", m, 0);
         @(posedge core_clk);
         stop_mode <= 1'b0;
      end
      final_report;
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      fails++;
      final_report;
   end
endmodule // tb_top

bind fllcs_top fllcs_chk_sva u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
   .main_clock_out(main_clock_out), .bus_clock_out(bus_clock_out),
   .debug_link_clock(debug_link_clock));
`default_nettype wire
